//--- design/hjs_regs.sv
// Purpose: two-wire slave and register bank of a magnetic joystick sensor
// Assumes: sample engine on the core clock; bus pins asynchronous
// Notes: one data byte per transaction; open-drain data and interrupt
//
// Functional notes
// - answer only at slave address 1000000
// - bits sampled on bus clock rising edge
// - device acks matching address with 0
// - second byte is register address, acked
// - one data byte; final ack slot is 1
// - nack wrong address or read-only write
// - main control access releases the interrupt
// - bits 7,6 select power mode, reset 1,0
// - shutdown: threshold crossing drives interrupt low
// - low power irq per result; full holds
// - soft reset bit restores all reset values
// - bit 0 flags valid coordinates, reset 0
// - secondary bit 1 inverts hall sense
// - four signed thresholds with reset values
// - read-only X/Y positions reset to zero
// - release-register reads return coordinate, release irq
// - all registers reachable over serial bus
// - shutdown wakes every 80 ms
// - low power wakes every 20 ms
// - full power converts continuously
// - power mode change releases interrupt
`timescale 1ns/1ns
`default_nettype none
module hjs_regs
	import hjs_pkg::*;
#(
	parameter int SHUT_CYC = SHUT_WAKE_CYC,
	parameter int LOWP_CYC = LOWP_WAKE_CYC
)(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	output logic irq_out_low,
	input wire hjs_sample_t sample_in,
	output logic wake_out,
	output logic pulsed_sampling_sel_out,
	output logic active_power_sel_out,
	output logic invert_sense_out
);

	localparam logic [23:0] SHUT_LAST = 24'(SHUT_CYC - 1);
	localparam logic [23:0] LOWP_LAST = 24'(LOWP_CYC - 1);

	hjs_state_t s_reg;
	hjs_state_t s_next;
	hjs_pins_t pin;
	logic [7:0] rd;
	logic [7:0] wdat;
	logic rel;
	logic set_irq;
	logic srst;
	logic hold;
	logic shut;
	logic lowp;
	logic full;

	hjs_pin_sync u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.pins_out(pin)
	);

	function automatic logic reg_mapped(input logic [7:0] a);
		return a == OFS_X_POS || a == OFS_Y_POS || a == OFS_X_REL || a == OFS_Y_REL ||
			a == OFS_XP_THR || a == OFS_XN_THR || a == OFS_YP_THR || a == OFS_YN_THR ||
			a == OFS_SEC_CTL || a == OFS_MAIN_CTL;
	endfunction

	function automatic logic reg_read_only(input logic [7:0] a);
		return a == OFS_X_POS || a == OFS_Y_POS || a == OFS_X_REL || a == OFS_Y_REL;
	endfunction

	function automatic logic [7:0] rd_data(input hjs_regs_t r, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			OFS_X_POS, OFS_X_REL: v = r.xpos;
			OFS_Y_POS, OFS_Y_REL: v = r.ypos;
			OFS_XP_THR: v = r.xp;
			OFS_XN_THR: v = r.xn;
			OFS_YP_THR: v = r.yp;
			OFS_YN_THR: v = r.yn;
			OFS_SEC_CTL: v = r.sec;
			OFS_MAIN_CTL: v = r.main;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// signed comparison against all four wake thresholds
	function automatic logic beyond(input hjs_regs_t r, input logic [7:0] x,
		input logic [7:0] y);
		return $signed(x) > $signed(r.xp) || $signed(x) < $signed(r.xn) ||
			$signed(y) > $signed(r.yp) || $signed(y) < $signed(r.yn);
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.wake = 1'b0;
		rel = 1'b0;
		set_irq = 1'b0;
		srst = 1'b0;
		rd = rd_data(s_reg.rf, s_reg.ra);
		wdat = {s_reg.shf[6:0], pin.sda};
		shut = s_reg.rf.main[MC_PULSED] && !s_reg.rf.main[MC_ACTIVE];
		lowp = s_reg.rf.main[MC_PULSED] && s_reg.rf.main[MC_ACTIVE];
		full = !s_reg.rf.main[MC_PULSED] && s_reg.rf.main[MC_ACTIVE];
		hold = full && s_reg.rf.main[MC_ACT_EN] && !s_reg.irq_n;

		// wake timer for the two pulsed modes
		if (shut || lowp) begin
			if (s_reg.tmr >= (lowp ? LOWP_LAST : SHUT_LAST)) begin
				s_next.tmr = 24'h000000;
				s_next.wake = 1'b1;
			end else begin
				s_next.tmr = s_reg.tmr + 24'h000001;
			end
		end else begin
			s_next.tmr = 24'h000000;
		end

		// serial slave; device only ever answers a master-started frame
		if (pin.start) begin
			s_next.bus = ST_DEV;
			s_next.cnt = 3'h0;
			s_next.drv = 1'b0;
			s_next.sda_lvl = 1'b1;
		end else if (pin.stop) begin
			s_next.bus = ST_IDLE;
			s_next.drv = 1'b0;
			s_next.sda_lvl = 1'b1;
		end else if (pin.scl_rise) begin
			unique case (s_reg.bus)
				ST_DEV, ST_REG, ST_WDAT: begin
					s_next.shf = wdat;
					s_next.cnt = s_reg.cnt + 3'h1;
					s_next.acked = 1'b0;
					if (s_reg.cnt == 3'h7 && s_reg.bus == ST_DEV) begin
						s_next.rnw = pin.sda;
						s_next.bus = (s_reg.shf[6:0] == BUS_ADDR) ? ST_ACK_DEV : ST_WAIT;
					end else if (s_reg.cnt == 3'h7 && s_reg.bus == ST_REG) begin
						s_next.ra = wdat;
						if (reg_mapped(wdat) && (s_reg.rnw || !reg_read_only(wdat))) begin
							s_next.bus = ST_ACK_REG;
							rel = (wdat == OFS_MAIN_CTL);
						end else begin
							s_next.bus = ST_WAIT;
						end
					end else if (s_reg.cnt == 3'h7) begin
						// single byte, then released ack slot and stop
						s_next.bus = ST_WAIT;
						unique case (s_reg.ra)
							OFS_XP_THR: s_next.rf.xp = wdat;
							OFS_XN_THR: s_next.rf.xn = wdat;
							OFS_YP_THR: s_next.rf.yp = wdat;
							OFS_YN_THR: s_next.rf.yn = wdat;
							OFS_SEC_CTL: s_next.rf.sec = wdat;
							default: begin
								s_next.rf.main = {wdat[7:1], s_reg.rf.main[MC_VALID]};
								if (wdat[7:6] != s_reg.rf.main[7:6]) begin
									rel = 1'b1;
									s_next.tmr = 24'h000000;
								end
								srst = wdat[MC_SRST];
							end
						endcase
					end
				end
				ST_ACK_DEV, ST_ACK_REG: s_next.acked = 1'b1;
				ST_RDAT: begin
					s_next.cnt = s_reg.cnt + 3'h1;
					if (s_reg.cnt == 3'h7) begin
						s_next.bus = ST_WAIT;
					end
				end
				ST_IDLE, ST_WAIT: s_next.acked = 1'b0;
				default: s_next.bus = ST_IDLE;
			endcase
		end else if (pin.scl_fall) begin
			unique case (s_reg.bus)
				ST_ACK_DEV, ST_ACK_REG: begin
					if (!s_reg.acked) begin
						// launched on the fall so it is stable at the rise
						s_next.drv = 1'b1;
						s_next.sda_lvl = 1'b0;
					end else begin
						s_next.drv = 1'b0;
						s_next.sda_lvl = 1'b1;
						s_next.cnt = 3'h0;
						s_next.acked = 1'b0;
						if (s_reg.bus == ST_ACK_DEV) begin
							s_next.bus = ST_REG;
						end else if (!s_reg.rnw) begin
							s_next.bus = ST_WDAT;
						end else begin
							s_next.bus = ST_RDAT;
							s_next.shf = {rd[6:0], 1'b0};
							s_next.sda_lvl = rd[7];
							s_next.drv = !rd[7];
							if (s_reg.ra == OFS_X_REL || s_reg.ra == OFS_Y_REL) begin
								rel = 1'b1;
								s_next.rf.main[MC_VALID] = 1'b0;
							end
						end
					end
				end
				ST_RDAT: begin
					s_next.sda_lvl = s_reg.shf[7];
					s_next.drv = !s_reg.shf[7];
					s_next.shf = {s_reg.shf[6:0], 1'b0};
				end
				ST_WAIT: begin
					s_next.drv = 1'b0;
					s_next.sda_lvl = 1'b1;
				end
				ST_IDLE, ST_DEV, ST_REG, ST_WDAT: s_next.drv = 1'b0;
				default: s_next.bus = ST_IDLE;
			endcase
		end

		// sample engine results; a held full-power sample waits for the interrupt release
		if (sample_in.valid && (shut || lowp || full) && !hold) begin
			s_next.rf.xpos = sample_in.x;
			s_next.rf.ypos = sample_in.y;
			s_next.rf.main[MC_VALID] = 1'b1;
			if (shut && s_reg.rf.main[MC_WUP_EN] && beyond(s_reg.rf, sample_in.x, sample_in.y)) begin
				set_irq = 1'b1;
			end
			if ((lowp || full) && s_reg.rf.main[MC_ACT_EN]) begin
				set_irq = 1'b1;
			end
		end

		// a new event beats a release in the same cycle
		if (set_irq) begin
			s_next.irq_n = 1'b0;
		end else if (rel) begin
			s_next.irq_n = 1'b1;
		end

		if (srst) begin
			s_next.rf = RF_RST;
			s_next.irq_n = 1'b1;
			s_next.tmr = 24'h000000;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '{ST_IDLE, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, RF_RST, 1'b1,
				24'h000000, 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign sda_out = s_reg.sda_lvl;
	assign sda_oe_n_out = !s_reg.drv;
	assign irq_out_low = s_reg.irq_n;
	assign wake_out = s_reg.wake;
	assign pulsed_sampling_sel_out = s_reg.rf.main[MC_PULSED];
	assign active_power_sel_out = s_reg.rf.main[MC_ACTIVE];
	assign invert_sense_out = s_reg.rf.sec[SC_INVERT];

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_addr_byte_done;
		s_reg.bus == ST_DEV && pin.scl_rise && !pin.start && s_reg.cnt == 3'h7;
	endsequence

	sequence s_ack_launch;
		s_reg.bus == ST_ACK_DEV && pin.scl_fall && !pin.start && !pin.stop && !s_reg.acked;
	endsequence

	chk_addr_nack: assert property (
		s_addr_byte_done and (s_reg.shf[6:0] != BUS_ADDR) |=> s_reg.bus == ST_WAIT && sda_oe_n_out)
		else $error("foreign address not ignored");

	chk_ack_low: assert property (
		s_ack_launch |=> !sda_oe_n_out && !sda_out)
		else $error("address ack not driven low");

	chk_ro_nack: assert property (
		s_reg.bus == ST_REG && pin.scl_rise && !pin.start && s_reg.cnt == 3'h7 && !s_reg.rnw &&
		reg_read_only(wdat) |=> s_reg.bus == ST_WAIT ##1 sda_oe_n_out)
		else $error("read-only write was acked");

	chk_main_release: assert property (
		rel && !set_irq && !srst |=> irq_out_low)
		else $error("interrupt not released");

	chk_srst_vals: assert property (
		srst |=> s_reg.rf == RF_RST && irq_out_low && pulsed_sampling_sel_out)
		else $error("soft reset left a register changed");

	chk_lp_irq: assert property (
		sample_in.valid && lowp && s_reg.rf.main[MC_ACT_EN] && !srst |=> !irq_out_low)
		else $error("low power result raised no interrupt");

	chk_full_hold: assert property (
		hold && !srst ##1 !rel |-> $stable(s_reg.rf.xpos) && $stable(s_reg.rf.ypos))
		else $error("held sample overwritten");

	chk_valid_bit: assert property (
		sample_in.valid && (shut || lowp || full) && !hold && !srst |=> s_reg.rf.main[MC_VALID])
		else $error("data valid not set");

	chk_wake_gap: assert property (
		wake_out && (shut || lowp) |=> !wake_out [*8])
		else $error("wake pulses too close");

endmodule // hjs_regs
`default_nettype wire

//--- design/hjs_pkg.sv
// Purpose: shared constants and types for the joystick sensor serial register block
// Assumes: 125 MHz core clock; two-wire bus pins sampled into that domain
// Notes: offsets, field positions, reset values and timing counts live only here
package hjs_pkg;

	// fixed 7-bit slave address 1000 000
	localparam logic [6:0] BUS_ADDR = 7'h40;

	// register offsets
	localparam logic [7:0] OFS_X_POS = 8'h41;
	localparam logic [7:0] OFS_Y_POS = 8'h42;
	localparam logic [7:0] OFS_XP_THR = 8'h43;
	localparam logic [7:0] OFS_XN_THR = 8'h44;
	localparam logic [7:0] OFS_X_REL = 8'h51;
	localparam logic [7:0] OFS_Y_REL = 8'h52;
	localparam logic [7:0] OFS_YP_THR = 8'h53;
	localparam logic [7:0] OFS_YN_THR = 8'h54;
	localparam logic [7:0] OFS_SEC_CTL = 8'h75;
	localparam logic [7:0] OFS_MAIN_CTL = 8'h76;

	// main control field positions
	localparam int MC_PULSED = 7;
	localparam int MC_ACTIVE = 6;
	localparam int MC_CONT = 5;
	localparam int MC_WUP_EN = 4;
	localparam int MC_ACT_EN = 3;
	localparam int MC_EXTCLK = 2;
	localparam int MC_SRST = 1;
	localparam int MC_VALID = 0;
	// secondary control field positions
	localparam int SC_INVERT = 1;

	// reset values
	localparam logic [7:0] MAIN_RST = 8'h98;
	localparam logic [7:0] SEC_RST = 8'h40;
	localparam logic [7:0] THR_POS_RST = 8'h28;
	localparam logic [7:0] THR_NEG_RST = 8'hd8;
	localparam logic [7:0] POS_RST = 8'h00;

	// wake periods
	localparam int CLK_HZ = 125_000_000;
	localparam int SHUT_WAKE_MS = 80;
	localparam int LOWP_WAKE_MS = 20;
	localparam int SHUT_WAKE_CYC = SHUT_WAKE_MS * (CLK_HZ / 1000);
	localparam int LOWP_WAKE_CYC = LOWP_WAKE_MS * (CLK_HZ / 1000);

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_DEV = 8'h02,
		ST_ACK_DEV = 8'h04,
		ST_REG = 8'h08,
		ST_ACK_REG = 8'h10,
		ST_WDAT = 8'h20,
		ST_RDAT = 8'h40,
		ST_WAIT = 8'h80
	} hjs_bus_st_t;

	typedef struct packed {
		logic valid;
		logic [7:0] x;
		logic [7:0] y;
	} hjs_sample_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} hjs_pins_t;

	typedef struct packed {
		logic [7:0] main;
		logic [7:0] sec;
		logic [7:0] xp;
		logic [7:0] xn;
		logic [7:0] yp;
		logic [7:0] yn;
		logic [7:0] xpos;
		logic [7:0] ypos;
	} hjs_regs_t;

	localparam hjs_regs_t RF_RST = '{MAIN_RST, SEC_RST, THR_POS_RST, THR_NEG_RST,
		THR_POS_RST, THR_NEG_RST, POS_RST, POS_RST};

	typedef struct packed {
		hjs_bus_st_t bus;
		logic [2:0] cnt;
		logic [7:0] shf;
		logic rnw;
		logic [7:0] ra;
		logic acked;
		logic drv;
		logic sda_lvl;
		hjs_regs_t rf;
		logic irq_n;
		logic [23:0] tmr;
		logic wake;
	} hjs_state_t;

endpackage

//--- design/hjs_pin_sync.sv
// Purpose: bring bus clock and data pins into the core clock domain
// Assumes: pins idle high; core clock well above twice the bus clock
// Notes: edges and start/stop derive from second and third stages only
`timescale 1ns/1ns
`default_nettype none
module hjs_pin_sync
	import hjs_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output hjs_pins_t pins_out
);

	typedef struct packed {
		logic [1:0] m1;
		logic [1:0] m2;
		logic [1:0] m3;
	} hjs_sync_t;

	hjs_sync_t s_reg;
	hjs_sync_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.m1 = {scl_in, sda_in};
		s_next.m2 = s_reg.m1;
		s_next.m3 = s_reg.m2;
	end

	// idle-high reset avoids a false start right after release
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '{2'h3, 2'h3, 2'h3};
		end else begin
			s_reg <= s_next;
		end
	end

	// one driver for the whole struct; per-field drivers of one variable are refused
	assign pins_out = '{
		scl: s_reg.m2[1],
		sda: s_reg.m2[0],
		scl_rise: s_reg.m2[1] && !s_reg.m3[1],
		scl_fall: !s_reg.m2[1] && s_reg.m3[1],
		start: s_reg.m2[1] && s_reg.m3[1] && !s_reg.m2[0] && s_reg.m3[0],
		stop: s_reg.m2[1] && s_reg.m3[1] && s_reg.m2[0] && !s_reg.m3[0]
	};

endmodule // hjs_pin_sync
`default_nettype wire

//--- test/hjs_host_model.sv
// Purpose: host bus master model for the two-wire sensor bus
// Assumes: core clock paces the bus, 8 core clocks per bus bit (64 ns)
// Notes: bus clock stands high between frames; released data reads high (pull-up)
`timescale 1ns/1ns
`default_nettype none
module hjs_host_model (
	input wire logic clk_in,
	input wire logic sda_wire_in,
	output var logic scl_out,
	output var logic sda_drv_out
);
	initial begin
		scl_out = 1'b1;
		sda_drv_out = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// data moves mid-low so it never races the clock fall through the syncs
	task automatic bit_io(input logic b, output logic s);
		tk(2);
		sda_drv_out = b;
		tk(2);
		scl_out = 1'b1;
		tk(4);
		s = sda_wire_in;
		scl_out = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] b, output logic [7:0] s);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s[i]);
		end
	endtask
	// acks: {slave address, register address, final slot}, 0 = acknowledged
	task automatic xfer(input logic [6:0] dev, input logic rnw, input logic [7:0] ra,
		input logic [7:0] wd, output logic [7:0] rd, output logic [2:0] acks);
		logic [7:0] junk;
		tk(4);
		sda_drv_out = 1'b0;
		tk(4);
		scl_out = 1'b0;
		byte_io({dev, rnw}, junk);
		bit_io(1'b1, acks[2]);
		byte_io(ra, junk);
		bit_io(1'b1, acks[1]);
		byte_io(rnw ? 8'hff : wd, rd);
		bit_io(1'b1, acks[0]);
		tk(2);
		sda_drv_out = 1'b0;
		tk(2);
		scl_out = 1'b1;
		tk(4);
		sda_drv_out = 1'b1;
	endtask
endmodule // hjs_host_model
`default_nettype wire

//--- test/tb_top.sv
// Purpose: self-checking bench for the sensor serial register block
// Assumes: bench acts as sample engine; wake periods shortened to 40 and 10
// Notes: open-drain data wire resolved here from both parties
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import hjs_pkg::*;
	localparam int SHUT = 40;
	localparam int LOWP = 10;
	logic clk_in, rst_in, scl, sda_m, sda_wire, sda_out, sda_oe_n, irq_n;
	logic wake, pulsed, active, invert;
	hjs_sample_t smp;
	int n_mismatch = 0;
	int samples_checked = 0;
	assign sda_wire = sda_m & (sda_oe_n | sda_out);
	hjs_host_model host (.clk_in(clk_in), .sda_wire_in(sda_wire), .scl_out(scl),
		.sda_drv_out(sda_m));
	hjs_regs #(.SHUT_CYC(SHUT), .LOWP_CYC(LOWP)) uut (.clk_in(clk_in), .rst_in(rst_in),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
		.irq_out_low(irq_n), .sample_in(smp), .wake_out(wake),
		.pulsed_sampling_sel_out(pulsed), .active_power_sel_out(active),
		.invert_sense_out(invert));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic acc(input logic [6:0] dev, input logic [7:0] ra, input logic rnw,
		input logic [7:0] wd, input logic [2:0] ea, input logic [7:0] ed);
		logic [7:0] d;
		logic [2:0] a;
		host.xfer(dev, rnw, ra, wd, d, a);
		cmp({5'h0, a}, {5'h0, ea}, "ack pattern");
		if (rnw) cmp(d, ed, "read data");
	endtask
	task automatic rd(input logic [7:0] ra, input logic [7:0] ed);
		acc(BUS_ADDR, ra, 1'b1, 8'h00, 3'b001, ed);
	endtask
	task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
		acc(BUS_ADDR, ra, 1'b0, wd, 3'b001, 8'h00);
	endtask
	task automatic outs(input logic i, input logic p, input logic a);
		cmp({5'h0, irq_n, pulsed, active}, {5'h0, i, p, a}, "irq and mode");
	endtask
	task automatic push(input logic [7:0] x, input logic [7:0] y);
		smp = '{1'b1, x, y};
		@(posedge clk_in);
		#1;
		smp.valid = 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task automatic period(input int exp);
		int n;
		n = 0;
		while (wake !== 1'b1 && n < 200) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (wake !== 1'b1 && n < 200);
		cmp(n[7:0], exp[7:0], "wake period");
	endtask
	task automatic t_reset;
		logic [7:0] ofs [10] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h51, 8'h52, 8'h53, 8'h54,
			8'h75, 8'h76};
		logic [7:0] val [10] = '{8'h00, 8'h00, 8'h28, 8'hd8, 8'h00, 8'h00, 8'h28, 8'hd8,
			8'h40, 8'h98};
		outs(1'b1, 1'b1, 1'b0);
		cmp({7'h0, invert}, 8'h00, "invert");
		for (int i = 0; i < 10; i++) begin
			rd(ofs[i], val[i]);
		end
	endtask
	task automatic t_access;
		wr(8'h43, 8'h7f);
		rd(8'h43, 8'h7f);
		wr(8'h54, 8'h80);
		rd(8'h54, 8'h80);
		wr(8'h75, 8'h42);
		cmp({7'h0, invert}, 8'h01, "invert");
		rd(8'h75, 8'h42);
		acc(BUS_ADDR, 8'h41, 1'b0, 8'h55, 3'b011, 8'h00);
		acc(BUS_ADDR, 8'h51, 1'b0, 8'h55, 3'b011, 8'h00);
		rd(8'h41, 8'h00);
		acc(BUS_ADDR, 8'h60, 1'b1, 8'h00, 3'b011, 8'hff);
		acc(7'h41, 8'h43, 1'b0, 8'h11, 3'b111, 8'h00);
		rd(8'h43, 8'h7f);
	endtask
	task automatic t_soft;
		wr(8'h76, 8'h9a);
		rd(8'h43, 8'h28);
		rd(8'h54, 8'hd8);
		rd(8'h75, 8'h40);
		cmp({7'h0, invert}, 8'h00, "invert");
		rd(8'h76, 8'h98);
	endtask
	task automatic t_shut;
		period(SHUT);
		push(8'h10, 8'hf0);
		outs(1'b1, 1'b1, 1'b0);
		push(8'h29, 8'h00);
		outs(1'b0, 1'b1, 1'b0);
		rd(8'h41, 8'h29);
		outs(1'b0, 1'b1, 1'b0);
		rd(8'h51, 8'h29);
		outs(1'b1, 1'b1, 1'b0);
		push(8'h00, 8'hd7);
		outs(1'b0, 1'b1, 1'b0);
		rd(8'h76, 8'h99);
		outs(1'b1, 1'b1, 1'b0);
		rd(8'h52, 8'hd7);
		rd(8'h76, 8'h98);
	endtask
	task automatic t_power;
		wr(8'h76, 8'hc8);
		outs(1'b1, 1'b1, 1'b1);
		period(LOWP);
		push(8'h05, 8'h05);
		outs(1'b0, 1'b1, 1'b1);
		wr(8'h76, 8'h48);
		outs(1'b1, 1'b0, 1'b1);
		push(8'h11, 8'h22);
		outs(1'b0, 1'b0, 1'b1);
		push(8'h33, 8'h44);
		rd(8'h41, 8'h11);
		rd(8'h52, 8'h22);
		outs(1'b1, 1'b0, 1'b1);
		push(8'h33, 8'h44);
		rd(8'h51, 8'h33);
	endtask
	initial begin
		smp = '0;
		rst_in = 1'b1;
		repeat (20) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
		t_reset();
		t_access();
		t_soft();
		t_shut();
		t_power();
		print_verdict();
	end
	// about 40 frames of ~250 clocks each, so this leaves ample margin
	initial begin
		repeat (60000) @(posedge clk_in);
		n_mismatch++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
